// *** design/eslpg_core.sv ***
// enable decode, sync lock oscillator and power-good flag
`timescale 1ns/100ps

// Contract
// RQ1: below wake threshold, stay shut down
// RQ2: wake band: rail on, no switching
// RQ3: switch only when enabled and supply good
// RQ4: ignore enable changes inside blanking window
// RQ5: no blanking while shut down
// RQ6: driver holds enable low beyond window
// RQ7: lock to rising sync edges in range
// RQ8: sync clock absent until start-up done
// RQ9: sync phases shorter than blanking window
// RQ10: jump to sync frequency after 2048
// RQ11: valid sync turns spread spectrum off
// RQ12: transition cycle of intermediate length
// RQ13: trim phase gradually onto sync edges
// RQ14: bad frequency resistor forces shutdown
// RQ15: flag low when feedback out of window
// RQ16: filter short excursions before pulling low
// RQ17: enable low forces flag low
// RQ18: flag only ever pulls low
// RQ19: lower frequency at on/off time limit
// RQ20: flag low through soft start
// RQ21: missed edge restarts lock count
module eslpg_core #(
	parameter logic [11:0] NAT_PERIOD = eslpg_pkg::NAT_DEF,  // free-running cycle
	parameter bit          SPREAD_OPT = 1'b1                 // spread variant
) (
	input  wire logic clk,
	input  wire logic reset,
	input  wire logic syncClk,
	input  wire logic enWake,
	input  wire logic enOn,
	input  wire logic vinOk,
	input  wire logic freqSetResistorOk,
	input  wire logic fbInWindow,
	input  wire logic thermalFault,
	input  wire logic softStartDone,
	input  wire logic minTimeLimit,
	input  wire logic powerGoodFlagIn,
	output logic      vccEnable,
	output logic      phaseNodeEnable,
	output logic      phaseNodePulse,
	output logic      syncLocked,
	output logic      spreadActive,
	output logic      powerGoodFlagOut,
	output logic      powerGoodFlagOe
);

	eslpg_pkg::eslpg_core_t cur;       // registered state
	eslpg_pkg::eslpg_core_t nx;        // next state
	eslpg_pkg::eslpg_link_t linkQ;     // link domain state
	eslpg_pkg::eslpg_link_t linkD;     // link domain next
	eslpg_pkg::eslpg_pins_t pins;      // raw inputs to synchronise
	logic                   edgeSeen;  // rising sync edge, main domain
	logic                   edgeOk;    // edge spacing within range
	logic                   wrap;      // oscillator cycle ends
	logic                   pgBad;     // raw flag fault
	logic                   pgForce;   // fault that skips the filter
	logic [11:0]            perNow;    // spacing of the edge just seen
	logic [11:0]            perSel;    // length chosen for next cycle

	// limit a phase error to one nudge
	function automatic logic [3:0] clampStep(input logic [11:0] e);
		clampStep = (e > 12'(eslpg_pkg::TRIM_STEP)) ? eslpg_pkg::TRIM_STEP : e[3:0];
	endfunction

	// link side: each rising sync edge flips a toggle
	always_comb
	begin
		linkD     = linkQ;
		linkD.r1  = reset;
		linkD.r2  = linkQ.r1;
		// the clock may stop between frames; the toggle just holds
		linkD.tgl = linkQ.r2 ? 1'b0 : ~linkQ.tgl;  // RQ7
	end

	always_ff @(posedge syncClk)
	begin
		linkQ <= linkD;
	end

	// every outside level passes two flops first
	assign pins = '{wake: enWake, on: enOn, vin: vinOk, rt: freqSetResistorOk,
		fb: fbInWindow, hot: thermalFault, ss: softStartDone,
		fold: minTimeLimit, tgl: linkQ.tgl};

	// main domain next state
	always_comb
	begin
		nx       = cur;
		nx.s1    = pins;
		nx.s2    = cur.s1;
		nx.tglPrev = cur.s2.tgl;
		edgeSeen = cur.s2.tgl ^ cur.tglPrev;
		perNow   = 12'(cur.sinceEdge + 12'h001);
		edgeOk   = (perNow >= eslpg_pkg::PER_MIN_CYC) && (perNow <= eslpg_pkg::PER_MAX_CYC);
		wrap     = 12'(cur.osc + 12'h001) >= cur.period;
		perSel   = NAT_PERIOD;

		// blanking starts on a sync edge, never in shutdown
		if (cur.mode == eslpg_pkg::ESL_SHUT)
		begin
			nx.blank = '0;  // RQ5
		end
		else if (edgeSeen)
		begin
			nx.blank = eslpg_pkg::BLANK_CYC;  // RQ4
		end
		else if (cur.blank != '0)
		begin
			nx.blank = 12'(cur.blank - 12'h001);
		end

		// enable levels follow the pin only outside the window
		if (cur.mode == eslpg_pkg::ESL_SHUT || cur.blank == '0)
		begin
			nx.wakeEff = cur.s2.wake;  // RQ4
			nx.enEff   = cur.s2.on;    // RQ5
		end

		// mode decode from the blanked levels
		unique case (cur.mode)
			eslpg_pkg::ESL_SHUT:
			begin
				if (cur.wakeEff && cur.s2.rt)
					nx.mode = eslpg_pkg::ESL_STBY;  // RQ2
			end
			eslpg_pkg::ESL_STBY:
			begin
				if (!cur.wakeEff || !cur.s2.rt)
					nx.mode = eslpg_pkg::ESL_SHUT;  // RQ1
				else if (cur.enEff && cur.s2.vin)
					nx.mode = eslpg_pkg::ESL_RUN;   // RQ3
			end
			eslpg_pkg::ESL_RUN:
			begin
				// a bad resistor reading drops straight to shutdown
				if (!cur.wakeEff || !cur.s2.rt)
					nx.mode = eslpg_pkg::ESL_SHUT;  // RQ14
				else if (!cur.enEff || !cur.s2.vin)
					nx.mode = eslpg_pkg::ESL_STBY;  // RQ3
			end
		endcase
		nx.vcc = nx.mode != eslpg_pkg::ESL_SHUT;  // RQ2
		nx.sw  = nx.mode == eslpg_pkg::ESL_RUN;   // RQ3

		// sync edge qualification and lock count
		if (cur.mode == eslpg_pkg::ESL_SHUT)
		begin
			nx.sinceEdge = '0;
			nx.edges     = '0;
			nx.locked    = 1'b0;
			nx.transit   = 1'b0;
		end
		else if (edgeSeen)
		begin
			nx.sinceEdge = '0;
			if (edgeOk)
			begin
				nx.lastPer = perNow;  // RQ7
				if (cur.edges == 12'(eslpg_pkg::LOCK_EDGES - 12'h001))
				begin
					// hold the count here so the jump happens once
					nx.transit = !cur.locked;  // RQ12
					nx.locked  = 1'b1;         // RQ10
				end
				else
				begin
					nx.edges = 12'(cur.edges + 12'h001);
				end
			end
			else
			begin
				nx.edges   = '0;  // RQ21
				nx.locked  = 1'b0;
				nx.transit = 1'b0;
			end
		end
		else if (cur.sinceEdge >= eslpg_pkg::PER_MAX_CYC)
		begin
			// no edge in time: lock must be earned again
			nx.edges   = '0;  // RQ21
			nx.locked  = 1'b0;
			nx.transit = 1'b0;
		end
		else
		begin
			nx.sinceEdge = 12'(cur.sinceEdge + 12'h001);
		end

		// phase error seen at each edge once locked
		if (edgeSeen && cur.locked && !cur.transit && cur.osc != '0)
		begin
			if (cur.osc < (cur.period >> 1))
			begin
				nx.trimUp = clampStep(cur.osc);  // RQ13
				nx.trimDn = '0;
			end
			else
			begin
				nx.trimDn = clampStep(12'(cur.period - cur.osc));  // RQ13
				nx.trimUp = '0;
			end
		end

		// length of the next switching cycle
		if (cur.transit)
		begin
			// halfway between old and new keeps the phase
			perSel = 12'((13'(cur.period) + 13'(cur.lastPer)) >> 1);  // RQ12
		end
		else if (cur.locked)
		begin
			perSel = 12'(cur.lastPer + 12'(cur.trimUp) - 12'(cur.trimDn));  // RQ13
		end
		else if (SPREAD_OPT && !cur.s2.fold)
		begin
			// up to one sixty-fourth either side, chosen per cycle
			if (cur.lfsr[0])
				perSel = 12'(NAT_PERIOD + ((NAT_PERIOD >> 6) & {4'h0, cur.lfsr}));
			else
				perSel = 12'(NAT_PERIOD - ((NAT_PERIOD >> 6) & {4'h0, cur.lfsr}));
		end
		if (cur.s2.fold)
		begin
			perSel = 12'(perSel << 1);  // RQ19
		end

		// oscillator runs only while switching is allowed
		nx.pulse = 1'b0;
		if (cur.mode != eslpg_pkg::ESL_RUN)
		begin
			nx.osc    = '0;
			nx.period = NAT_PERIOD;
		end
		else if (wrap)
		begin
			nx.osc     = '0;
			nx.pulse   = 1'b1;
			nx.period  = perSel;
			nx.lfsr    = {cur.lfsr[6:0], ~(cur.lfsr[7] ^ cur.lfsr[5] ^ cur.lfsr[4] ^ cur.lfsr[3])};
			nx.transit = 1'b0;
			if (!cur.transit)
			begin
				nx.trimUp = '0;
				nx.trimDn = '0;
			end
		end
		else
		begin
			nx.osc = 12'(cur.osc + 12'h001);
		end
		// lock or slowdown overrides spread
		nx.spread = SPREAD_OPT && nx.sw && !nx.locked && !cur.s2.fold;  // RQ11

		// power-good: hard faults act at once, feedback is filtered
		pgForce = !cur.enEff || cur.mode != eslpg_pkg::ESL_RUN || cur.s2.hot
			|| !cur.s2.ss;  // RQ20
		pgBad   = !cur.s2.fb;  // RQ15
		if (pgForce)
		begin
			nx.pgOk  = 1'b0;  // RQ17
			nx.pgCnt = '0;
		end
		else if (pgBad == cur.pgOk)
		begin
			// disagreement must last the whole filter time
			if (cur.pgCnt >= (cur.pgOk ? eslpg_pkg::PG_FALL_CYC : eslpg_pkg::PG_RISE_CYC)
				- 12'h001)
			begin
				nx.pgOk  = !cur.pgOk;  // RQ16
				nx.pgCnt = '0;
			end
			else
			begin
				nx.pgCnt = 12'(cur.pgCnt + 12'h001);
			end
		end
		else
		begin
			nx.pgCnt = '0;  // RQ16
		end
	end

	// main domain register
	always_ff @(posedge clk)
	begin
		if (reset)
			cur <= eslpg_pkg::CORE_RST;
		else
			cur <= nx;
	end

	// outputs straight from the state
	assign vccEnable        = cur.vcc;
	assign phaseNodeEnable  = cur.sw;
	assign phaseNodePulse   = cur.pulse;
	assign syncLocked       = cur.locked;
	assign spreadActive     = cur.spread;
	// open drain: pull low or let go, never drive high
	assign powerGoodFlagOut = 1'b0;       // RQ18
	assign powerGoodFlagOe  = ~cur.pgOk;  // RQ15

	default clocking dc @(posedge clk);
	endclocking
	default disable iff (reset);

	// shutdown keeps rail and switching off
	property p_shut;
		cur.mode == eslpg_pkg::ESL_SHUT |-> !vccEnable && !phaseNodeEnable;
	endproperty
	a_shut: assert property (p_shut) else $error("output active in shutdown"); // RQ1

	// standby: rail on, phase node quiet
	property p_stby;
		cur.mode == eslpg_pkg::ESL_STBY |-> vccEnable && !phaseNodeEnable;
	endproperty
	a_stby: assert property (p_stby) else $error("standby state wrong"); // RQ2

	// switching starts only after enable and supply were good
	property p_run;
		$rose(phaseNodeEnable) |-> $past(cur.enEff) && $past(cur.s2.vin);
	endproperty
	a_run: assert property (p_run) else $error("switching without enable"); // RQ3

	// blanked enable level holds
	property p_blank;
		cur.blank > 12'h001 && cur.mode != eslpg_pkg::ESL_SHUT ##1
			cur.mode != eslpg_pkg::ESL_SHUT |-> $stable(cur.enEff);
	endproperty
	a_blank: assert property (p_blank) else $error("enable moved in window"); // RQ4

	// in shutdown the level is taken as it comes
	property p_noblank;
		cur.mode == eslpg_pkg::ESL_SHUT |=> cur.enEff == $past(cur.s2.on);
	endproperty
	a_noblank: assert property (p_noblank) else $error("blanking in shutdown"); // RQ5

	// lock comes only on the last counted edge
	property p_lock;
		$rose(syncLocked) |-> $past(cur.edges) == 2047 && $past(edgeSeen);
	endproperty
	a_lock: assert property (p_lock) else $error("lock before full count"); // RQ10

	// no spread while locked
	property p_spread;
		syncLocked |-> !spreadActive;
	endproperty
	a_spread: assert property (p_spread) else $error("spread while locked"); // RQ11

	// enable low pulls the flag on the next cycle
	property p_pgen;
		!cur.enEff |=> powerGoodFlagOe && !powerGoodFlagOut;
	endproperty
	a_pgen: assert property (p_pgen) else $error("flag released while off"); // RQ17

	// missing edge clears the count
	property p_miss;
		cur.sinceEdge >= eslpg_pkg::PER_MAX_CYC && !edgeSeen |=> cur.edges == '0;
	endproperty
	a_miss: assert property (p_miss) else $error("count kept after gap"); // RQ21

	// bad resistor leaves run next cycle
	property p_rt;
		cur.mode == eslpg_pkg::ESL_RUN && !cur.s2.rt |=> cur.mode == eslpg_pkg::ESL_SHUT;
	endproperty
	a_rt: assert property (p_rt) else $error("ran with bad resistor"); // RQ14

endmodule // eslpg_core

// *** design/eslpg_pkg.sv ***
// package: constants and types for the enable, sync lock and power-good block
package eslpg_pkg;
	localparam int          ESL_CW       = 12;       // width of every cycle counter
	localparam int          CLK_KHZ      = 250000;   // main clock, 4 ns period
	localparam int          BLANK_MIN_NS = 4000;     // shortest enable blanking window
	localparam int          BLANK_MAX_NS = 28000;    // longest enable blanking window
	localparam int          SYNC_MIN_KHZ = 200;      // slowest sync clock
	localparam int          SYNC_MAX_KHZ = 2200;     // fastest sync clock
	localparam int          PG_FALL_NS   = 1000;     // flag fall filter time
	localparam int          PG_RISE_NS   = 2000;     // flag rise filter time
	// least times round up, longest times round down
	localparam logic [11:0] BLANK_CYC    = 12'((BLANK_MIN_NS * CLK_KHZ + 999999) / 1000000);
	localparam logic [11:0] PER_MIN_CYC  = 12'((CLK_KHZ + SYNC_MAX_KHZ - 1) / SYNC_MAX_KHZ);
	localparam logic [11:0] PER_MAX_CYC  = 12'(CLK_KHZ / SYNC_MIN_KHZ);
	localparam logic [11:0] PG_FALL_CYC  = 12'((PG_FALL_NS * (CLK_KHZ / 1000) + 999) / 1000);
	localparam logic [11:0] PG_RISE_CYC  = 12'((PG_RISE_NS * (CLK_KHZ / 1000) + 999) / 1000);
	localparam logic [11:0] LOCK_EDGES   = 12'h800;  // valid edges before the jump
	localparam logic [3:0]  TRIM_STEP    = 4'h4;     // phase nudge per cycle, cycles
	localparam logic [11:0] NAT_DEF      = 12'h271;  // free-running period, 400 kHz

	// operating modes decoded from the enable level
	typedef enum logic [1:0] {ESL_SHUT, ESL_STBY, ESL_RUN} eslpg_mode_t;

	// pins and link toggle, as they pass the synchronisers
	typedef struct packed {
		logic wake;  // above wake threshold
		logic on;    // above enable threshold
		logic vin;   // supply above minimum
		logic rt;    // frequency resistor in range
		logic fb;    // feedback inside flag window
		logic hot;   // thermal shutdown
		logic ss;    // soft start finished
		logic fold;  // on/off time limit reached
		logic tgl;   // sync edge toggle from link domain
	} eslpg_pins_t;

	// whole state of the main domain
	typedef struct packed {
		eslpg_pins_t s1;         // first synchroniser stage
		eslpg_pins_t s2;         // second synchroniser stage
		logic        tglPrev;    // toggle, one stage later
		eslpg_mode_t mode;       // shutdown, standby, run
		logic        wakeEff;    // blanked wake level
		logic        enEff;      // blanked enable level
		logic [11:0] blank;      // blanking cycles left
		logic [11:0] sinceEdge;  // cycles since last sync edge
		logic [11:0] lastPer;    // last valid sync period
		logic [11:0] edges;      // unbroken valid edge count
		logic        locked;     // running on the sync clock
		logic        transit;    // intermediate cycle pending
		logic [11:0] osc;        // oscillator phase count
		logic [11:0] period;     // current cycle length
		logic [3:0]  trimUp;     // phase lengthen request
		logic [3:0]  trimDn;     // phase shorten request
		logic [7:0]  lfsr;       // spread pattern
		logic [11:0] pgCnt;      // flag filter count
		logic        pgOk;       // flag released
		logic        vcc;        // regulator rail on
		logic        sw;         // phase node allowed
		logic        pulse;      // start of switching cycle
		logic        spread;     // spread spectrum active
	} eslpg_core_t;

	localparam eslpg_core_t CORE_RST = eslpg_core_t'(0);  // shutdown, flag low

	// link domain: reset synchroniser and edge toggle
	typedef struct packed {
		logic r1;   // reset, first stage
		logic r2;   // reset, second stage
		logic tgl;  // flips on every rising sync edge
	} eslpg_link_t;

	localparam eslpg_link_t LINK_RST = eslpg_link_t'(0);  // toggle cleared
endpackage

// *** test/eslpg_sync_src.sv ***
// far-side model: external sync clock source on the enable/sync line
`timescale 1ns/100ps
module eslpg_sync_src #(
	parameter realtime HALF_NS  = 16.0,  // half period of the sync clock
	parameter realtime START_NS = 1.3    // offset, unrelated to the main clock
) (
	input  wire logic run,
	output logic      syncClk
);
	// idle low between bursts, a stopped clock shows no edges
	// offset keeps rising edges off the main clock's edges
	always
	begin
		syncClk = 1'b0;
		wait (run === 1'b1);
		#(HALF_NS + START_NS) syncClk = 1'b1;
		#(HALF_NS - START_NS) syncClk = 1'b0;
	end
endmodule // eslpg_sync_src

// *** test/enable_sync_lock_power_good_test.sv ***
// self-checking bench for the enable, sync lock and power-good block
`timescale 1ns/100ps
module enable_sync_lock_power_good_test;
	localparam logic [11:0] NAT = 12'h064;  // short cycle keeps the run brief

	logic        clk;          // main clock
	logic        reset;        // synchronous reset
	logic        syncRun;      // burst request to the sync source
	wire logic   syncClk;      // link clock from the partner
	logic        enWake;       // above wake threshold
	logic        enOn;         // above enable threshold
	logic        vinOk;        // supply good
	logic        rtOk;         // frequency resistor in range
	logic        fbIn;         // feedback inside window
	logic        hot;          // thermal fault
	logic        ssDone;       // soft start finished
	logic        foldIn;       // on/off time limit
	logic        vcc;          // rail on
	logic        swEn;         // switching allowed
	logic        swPulse;      // cycle start
	logic        locked;       // running on sync clock
	logic        spread;       // dithering active
	logic        pgOut;        // flag drive value
	logic        pgOe;         // flag pulled low
	wire logic   pgWire;       // flag wire with pull-up
	int          n_fail;       // mismatches
	int          comparisons;  // compares made
	int          cycles;       // timeout count
	int          seed;         // random seed
	int          i;            // loop index
	logic [11:0] gap;          // measured cycle length
	logic [11:0] len;          // excursion length

	// open drain wire: pull-up unless the block pulls low
	assign pgWire = pgOe ? 1'b0 : 1'b1;

	eslpg_core #(
		.NAT_PERIOD (NAT),
		.SPREAD_OPT (1'b1)
	) i_eslpg_core (
		.clk               (clk),
		.reset             (reset),
		.syncClk           (syncClk),
		.enWake            (enWake),
		.enOn              (enOn),
		.vinOk             (vinOk),
		.freqSetResistorOk (rtOk),
		.fbInWindow        (fbIn),
		.thermalFault      (hot),
		.softStartDone     (ssDone),
		.minTimeLimit      (foldIn),
		.powerGoodFlagIn   (pgWire),
		.vccEnable         (vcc),
		.phaseNodeEnable   (swEn),
		.phaseNodePulse    (swPulse),
		.syncLocked        (locked),
		.spreadActive      (spread),
		.powerGoodFlagOut  (pgOut),
		.powerGoodFlagOe   (pgOe)
	);

	eslpg_sync_src i_eslpg_sync_src (
		.run     (syncRun),
		.syncClk (syncClk)
	);

	// main clock, 4 ns
	initial
	begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end

	// hang guard, well above the expected run length
	always @(posedge clk)
	begin
		cycles++;
		if (cycles == 32'h0000_7530)
		begin
			n_fail++;
			summarize();
		end
	end

	// verdict and end of run
	task automatic summarize();
		$display("comparisons %0d mismatches %0d", comparisons, n_fail);
		if (n_fail == 0 && comparisons > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	// single-bit level compare
	task automatic chkBit(input logic got, input logic exp);
		comparisons++;
		if (got !== exp)
		begin
			n_fail++;
			$display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// count compare against an allowed band
	task automatic chkNum(input logic [11:0] got, input logic [11:0] lo, input logic [11:0] hi);
		logic ok;
		ok = (got >= lo) && (got <= hi);
		comparisons++;
		if (ok !== 1'b1)
		begin
			n_fail++;
			$display("FAIL t=%0t got=%h exp=%h..%h", $time, got, lo, hi);
		end
	endtask

	// inputs move on falling edges only
	task automatic cyc(input int n);
		repeat (n) @(negedge clk);
	endtask

	// cycles from one switching pulse to the next, bounded wait
	task automatic measure(output logic [11:0] g);
		int k;
		k = 0;
		while (swPulse !== 1'b1 && k < 32'h0000_1000)
		begin
			@(negedge clk);
			k++;
		end
		g = 12'h001;
		@(negedge clk);
		while (swPulse !== 1'b1 && g < 12'hFFF)
		begin
			@(negedge clk);
			g++;
		end
	endtask

	// main sequence
	initial
	begin
		seed = 33842;
		n_fail = 0;
		comparisons = 0;
		cycles = 0;
		reset = 1'b1;
		// link side has no reset of its own: a few edges under reset clear it
		syncRun = 1'b1;
		{enWake, enOn, vinOk, fbIn, hot, ssDone, foldIn} = 7'h00;
		rtOk = 1'b1;
		repeat (20) @(posedge clk);
		@(negedge clk);
		reset = 1'b0;
		syncRun = 1'b0;
		chkBit(pgOe, 1'b1);
		cyc(16'h000A);
		chkBit(vcc, 1'b0);
		// wake band: rail only
		enWake = 1'b1;
		cyc(16'h0008);
		chkBit(vcc, 1'b1);
		chkBit(swEn, 1'b0);
		// enable without supply must not switch
		enOn = 1'b1;
		cyc(16'h000A);
		chkBit(swEn, 1'b0);
		vinOk = 1'b1;
		cyc(16'h0008);
		chkBit(swEn, 1'b1);
		// free-running cycle with spread dither of one step
		measure(gap);
		chkNum(gap, 12'h063, 12'h065);
		chkBit(spread, 1'b1);
		chkBit(locked, 1'b0);
		// time limit stretches the cycle
		foldIn = 1'b1;
		measure(gap);
		measure(gap);
		chkNum(gap, 12'h0C4, 12'h0CC);
		foldIn = 1'b0;
		// flag held through soft start, then released by the rise filter
		fbIn = 1'b1;
		cyc(16'h012C);
		chkBit(pgOe, 1'b1);
		ssDone = 1'b1;
		cyc(16'h0208);
		chkBit(pgOe, 1'b0);
		chkBit(pgOut, 1'b0);
		chkBit(pgWire, 1'b1);
		// random short excursions stay filtered
		for (i = 0; i < 8; i++)
		begin
			len = 12'h00A + 12'($unsigned($random(seed)) % 32'h0000_00DC);
			fbIn = 1'b0;
			cyc(int'(len));
			fbIn = 1'b1;
			cyc(16'h0004);
			chkBit(pgOe, 1'b0);
		end
		// a long excursion trips the flag
		fbIn = 1'b0;
		cyc(16'h010E);
		chkBit(pgOe, 1'b1);
		fbIn = 1'b1;
		cyc(16'h0208);
		chkBit(pgOe, 1'b0);
		// thermal fault pulls low at once
		hot = 1'b1;
		cyc(16'h0006);
		chkBit(pgOe, 1'b1);
		hot = 1'b0;
		cyc(16'h0208);
		// enable drop hidden by blanking while edges arrive
		syncRun = 1'b1;
		cyc(16'h0014);
		enOn = 1'b0;
		cyc(16'h012C);
		chkBit(swEn, 1'b1);
		chkBit(locked, 1'b0);
		syncRun = 1'b0;
		cyc(16'h01F4);
		chkBit(swEn, 1'b1);
		cyc(16'h0226);
		chkBit(swEn, 1'b0);
		chkBit(pgOe, 1'b1);
		// low held past the longest window stays off
		cyc(16'h1B58);
		chkBit(swEn, 1'b0);
		chkBit(pgOe, 1'b1);
		// in shutdown, edges must not blank the wake-up
		enWake = 1'b0;
		cyc(16'h000A);
		chkBit(vcc, 1'b0);
		syncRun = 1'b1;
		cyc(16'h0014);
		enWake = 1'b1;
		cyc(16'h000A);
		chkBit(vcc, 1'b1);
		syncRun = 1'b0;
		// run again once blanking ends, then lose the resistor while running
		enOn = 1'b1;
		cyc(16'h0410);
		chkBit(swEn, 1'b1);
		rtOk = 1'b0;
		cyc(16'h03FC);
		chkBit(vcc, 1'b0);
		chkBit(swEn, 1'b0);
		// second reset in mid-run
		rtOk = 1'b1;
		enOn = 1'b1;
		cyc(16'h03FC);
		reset = 1'b1;
		cyc(16'h0004);
		chkBit(vcc, 1'b0);
		chkBit(pgOe, 1'b1);
		reset = 1'b0;
		cyc(16'h0004);
		summarize();
	end
endmodule // enable_sync_lock_power_good_test
